/* File: logic/epod_pkg.sv */
// shared constants, register map and helpers of the encoder pulse output divider
package epod_pkg;
  // clock and timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int EDGE_MIN_NS = 40;
  localparam int EDGE_MIN_CYC_I = (EDGE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] EDGE_MIN_CYC = 3'(EDGE_MIN_CYC_I);
  localparam logic [1:0] BOOT_CYC = 2'h3;
  localparam logic [1:0] INDEX_EDGES = 2'h2;
  // parameter limits and reset values
  localparam logic [12:0] RES_MIN = 13'h0001;
  localparam logic [12:0] RES_MAX = 13'h1000;
  localparam logic [12:0] RES_RST = 13'h0014;
  localparam logic DIR_RST = 1'b0;
  localparam logic DIR_BOTH = 1'b1;
  localparam logic [31:0] PITCH_RST = 32'h0000_07D0;
  localparam logic [15:0] SPEED_RST = 16'h0032;
  localparam logic [15:0] COUNTS_RST = 16'h0400;
  localparam logic [47:0] LIMIT_NUM = 48'h0000_0000_0048;
  localparam logic [47:0] LIMIT_DEN = 48'h0000_0000_0064;
  localparam logic [2:0] MASK_RST = 3'h0;
  // bus
  localparam int AXI_ADDR_W = 8;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_RES = 8'h04;
  localparam logic [7:0] OFF_DIR = 8'h08;
  localparam logic [7:0] OFF_PITCH = 8'h0C;
  localparam logic [7:0] OFF_SPEED = 8'h10;
  localparam logic [7:0] OFF_COUNTS = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_MASK = 8'h1C;
  localparam logic [7:0] OFF_MON_LO = 8'h20;
  localparam logic [7:0] OFF_MON_HI = 8'h24;
  localparam logic [7:0] OFF_POS = 8'h28;
  // field positions
  localparam int CTRL_RESTART = 0;
  localparam int CTRL_CFG_ERR = 1;
  localparam int CTRL_SERIAL = 2;
  localparam int ST_SET_ERR = 0;
  localparam int ST_OVERSPEED = 1;
  localparam int ST_INDEX = 2;
  localparam int ZSLOTS = 4;
  localparam logic [2:0] ZSLOTS_W = 3'h4;

  // quadrature level pair to a 0..3 count phase
  function automatic logic [1:0] quad_code(input logic a, input logic b);
    quad_code = a ? (b ? 2'h2 : 2'h1) : (b ? 2'h3 : 2'h0);
  endfunction

  // byte-lane merge of a write into an old word
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    wmerge = r;
  endfunction
endpackage

/* File: logic/epod_sync.sv */
// two-stage pin synchroniser with rising-edge pulse
`timescale 1ns/10ps
module epod_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic q,
  output logic rise
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } epod_sync_s;

  epod_sync_s st;
  epod_sync_s next_st;

  // shift chain, first stage feeds only the second
  always_comb begin
    next_st = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.s2;
  assign rise = st.s2 & ~st.s3;
endmodule

/* File: logic/epod_zslot.sv */
// one stored zero-point position with compare
`timescale 1ns/10ps
module epod_zslot (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic load,
  input wire logic [31:0] load_pos,
  input wire logic [31:0] cmp_pos,
  output logic match
);
  typedef struct packed {
    logic valid;
    logic [31:0] pos;
  } epod_zslot_s;

  epod_zslot_s st;
  epod_zslot_s next_st;

  // clear wins over load
  always_comb begin
    next_st = st;
    if (clear) begin
      next_st.valid = 1'b0;
    end else if (load) begin
      next_st.valid = 1'b1;
      next_st.pos = load_pos;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign match = st.valid && (st.pos == cmp_pos);
endmodule

/* File: logic/epod_top.sv */
// encoder pulse output divider: scale decode, divider, phase-C gating, alarms, AXI4-Lite
// Behaviour
// R1 - with direction select at 1 the zero-point pulse is emitted in reverse travel too.
// R2 - with direction select at default the pulse is emitted only on forward passage.
// R3 - every zero point of a multi-zero scale gets its own first-passage gating; the code stores only four points, later points get none.
// R4 - with a serial converter unit the pulse is emitted both ways, select ignored.
// R5 - output resolution accepts 1 to 4096 edges per pitch, default 20.
// R6 - four-fold feedback counts per pitch are divided down to the set edge count.
// R7 - resolution is bounded by pitch/100 divided by max speed times 72.
// R8 - out-of-range or over-limit resolution raises the setting error alarm.
// R9 - output edges faster than the resolution allows raise the overspeed alarm.
// R10 - a recognised scale pitch replaces the pitch setting and shows on monitors; the code ignores it when a serial converter is present at restart.
// R11 - outputs A and B are in quadrature, 90 degrees apart.
// R12 - the zero-point pulse lasts as long as a phase-A pulse.
// R13 - a position stored on forward passage yields a pulse when crossed either way.
// R14 - after power-up reverse-only crossings give no pulse until a forward pass.
// R15 - parameters are taken only at restart, and restart clears stored positions.
`timescale 1ns/10ps
module epod_top (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic SCALE_A,
  input wire logic SCALE_B,
  input wire logic SCALE_Z,
  input wire logic SERIAL_CONV,
  input wire logic PITCH_AUTO_VALID,
  input wire logic [31:0] PITCH_AUTO,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [epod_pkg::AXI_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [epod_pkg::AXI_ADDR_W-1:0] S_AXI_ARADDR,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic QUAD_OUT_A,
  output logic QUAD_OUT_B,
  output logic INDEX_OUT,
  output logic ALARM_SET_ERR,
  output logic ALARM_OVERSPEED,
  output logic IRQ
);
  import epod_pkg::*;

  typedef struct packed {
    logic [1:0] boot;
    logic awready;
    logic aw_held;
    logic [7:0] awaddr;
    logic wready;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [12:0] stg_res;
    logic stg_dir;
    logic [31:0] stg_pitch;
    logic [15:0] stg_speed;
    logic [15:0] stg_counts;
    logic [12:0] res;
    logic dir;
    logic serial;
    logic [15:0] counts;
    logic cfg_err;
    logic [31:0] mon_pitch;
    logic [1:0] fb_code;
    logic fb_dir;
    logic [31:0] pos;
    logic [15:0] acc;
    logic [1:0] q;
    logic [2:0] spc;
    logic idx_on;
    logic [1:0] idx_cnt;
    logic [2:0] fill;
    logic [2:0] status;
    logic [2:0] mask;
    logic qa;
    logic qb;
    logic qidx;
    logic irq;
    logic al_set;
    logic al_ovs;
  } epod_state_s;

  epod_state_s st;
  epod_state_s next_st;

  logic a_q;
  logic b_q;
  logic z_q;
  logic z_rise;
  logic ser_q;
  logic [1:0] fb_new;
  logic fb_fwd;
  logic fb_rev;
  logic [31:0] pos_next;
  logic [ZSLOTS-1:0] slot_load;
  logic [ZSLOTS-1:0] slot_match;
  logic slot_clear;

  // pin synchronisers
  epod_sync u_sync_a (.clk(CORE_CLK), .rst(SYS_RST), .din(SCALE_A), .q(a_q), .rise());
  epod_sync u_sync_b (.clk(CORE_CLK), .rst(SYS_RST), .din(SCALE_B), .q(b_q), .rise());
  epod_sync u_sync_z (.clk(CORE_CLK), .rst(SYS_RST), .din(SCALE_Z), .q(z_q), .rise(z_rise));
  epod_sync u_sync_s (.clk(CORE_CLK), .rst(SYS_RST), .din(SERIAL_CONV), .q(ser_q), .rise());

  // x4 feedback decode, no steps while booting
  assign fb_new = quad_code(a_q, b_q);
  assign fb_fwd = (st.boot == 2'h0) && (fb_new == 2'(st.fb_code + 2'h1));
  assign fb_rev = (st.boot == 2'h0) && (fb_new == 2'(st.fb_code - 2'h1));
  assign pos_next = fb_fwd ? 32'(st.pos + 32'h0000_0001) :
                    fb_rev ? 32'(st.pos - 32'h0000_0001) : st.pos;

  // R3 one slot per zero point, four slots for the first four points
  for (genvar i = 0; i < ZSLOTS; i++) begin : g_slot
    epod_zslot u_slot (
      .clk(CORE_CLK),
      .rst(SYS_RST),
      .clear(slot_clear),
      .load(slot_load[i]),
      .load_pos(pos_next),
      .cmp_pos(pos_next),
      .match(slot_match[i])
    );
  end

  // next-state logic
  always_comb begin
    logic restart;
    logic run;
    logic both;
    logic zdir;
    logic emit;
    logic up;
    logic dn;
    logic edge_out;
    logic ovs;
    logic err;
    logic auto_ok;
    logic [16:0] sum;
    logic [31:0] pitch_sel;
    logic [47:0] lhs;
    logic [47:0] rhs;
    logic [2:0] w1c;
    logic [2:0] set;
    logic [7:0] waddr;
    logic [7:0] raddr;
    restart = 1'b0;
    run = ~st.cfg_err;
    both = (st.dir == DIR_BOTH) | st.serial;
    zdir = fb_fwd ? 1'b1 : (fb_rev ? 1'b0 : st.fb_dir);
    emit = 1'b0;
    up = 1'b0;
    dn = 1'b0;
    edge_out = 1'b0;
    ovs = 1'b0;
    err = 1'b0;
    auto_ok = PITCH_AUTO_VALID & ~ser_q;
    sum = 17'(st.acc) + 17'(st.res);
    pitch_sel = st.stg_pitch;
    lhs = '0;
    rhs = '0;
    w1c = '0;
    set = '0;
    waddr = {st.awaddr[7:2], 2'b00};
    raddr = {S_AXI_ARADDR[7:2], 2'b00};
    slot_load = '0;
    slot_clear = 1'b0;
    next_st = st;

    // boot countdown, one restart once the synchronisers hold pin levels
    if (st.boot != 2'h0) begin
      next_st.boot = 2'(st.boot - 2'h1);
      next_st.fb_code = fb_new;
      restart = (st.boot == 2'h1);
    end else begin
      next_st.fb_code = fb_new;
    end
    next_st.pos = pos_next;
    if (fb_fwd | fb_rev) begin
      next_st.fb_dir = fb_fwd;
    end

    // R6 rate divider on four-fold counts
    if (run && fb_fwd) begin
      if (sum >= 17'(st.counts)) begin
        next_st.acc = 16'(sum - 17'(st.counts));
        up = 1'b1;
      end else begin
        next_st.acc = 16'(sum);
      end
    end else if (run && fb_rev) begin
      if (st.acc >= 16'(st.res)) begin
        next_st.acc = 16'(st.acc - 16'(st.res));
      end else begin
        next_st.acc = 16'(17'(st.acc) + 17'(st.counts) - 17'(st.res));
        dn = 1'b1;
      end
    end
    edge_out = up | dn;

    // R11 quadrature phase counter
    if (up) begin
      next_st.q = 2'(st.q + 2'h1);
    end else if (dn) begin
      next_st.q = 2'(st.q - 2'h1);
    end

    // R9 edge spacing watch
    if (edge_out) begin
      ovs = (st.spc != 3'h0);
      next_st.spc = 3'(EDGE_MIN_CYC - 3'h1);
    end else if (st.spc != 3'h0) begin
      next_st.spc = 3'(st.spc - 3'h1);
    end

    // R1 R2 R4 zero-point gating by direction
    if (run && st.boot == 2'h0) begin
      // R13 R14 reverse only through stored points
      emit = (z_rise & (both | zdir)) | (~both & fb_rev & (|slot_match));
      // R3 store each new forward zero point while fewer than four are held
      if (z_rise && zdir && !(|slot_match) && st.fill < ZSLOTS_W) begin
        slot_load[st.fill[1:0]] = 1'b1;
        next_st.fill = 3'(st.fill + 3'h1);
      end
    end

    // R12 index held for the two edges of a phase-A pulse
    if (emit) begin
      next_st.idx_on = 1'b1;
      next_st.idx_cnt = 2'h0;
    end else if (st.idx_on && edge_out) begin
      if (st.idx_cnt == 2'(INDEX_EDGES - 2'h1)) begin
        next_st.idx_on = 1'b0;
      end else begin
        next_st.idx_cnt = 2'(st.idx_cnt + 2'h1);
      end
    end

    // AXI write address and data capture
    if (S_AXI_AWVALID && st.awready) begin
      next_st.aw_held = 1'b1;
      next_st.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && st.wready) begin
      next_st.w_held = 1'b1;
      next_st.wdata = S_AXI_WDATA;
      next_st.wstrb = S_AXI_WSTRB;
    end
    if (st.bvalid && S_AXI_BREADY) begin
      next_st.bvalid = 1'b0;
    end

    // register write
    if (st.aw_held && st.w_held && !st.bvalid) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = AXI_OKAY;
      unique case (waddr)
        OFF_CTRL: restart = restart | (st.wstrb[0] & st.wdata[CTRL_RESTART]);
        OFF_RES: next_st.stg_res = 13'(wmerge(32'(st.stg_res), st.wdata, st.wstrb));
        OFF_DIR: next_st.stg_dir = st.wstrb[0] ? st.wdata[0] : st.stg_dir;
        OFF_PITCH: next_st.stg_pitch = wmerge(st.stg_pitch, st.wdata, st.wstrb);
        OFF_SPEED: next_st.stg_speed = 16'(wmerge(32'(st.stg_speed), st.wdata, st.wstrb));
        OFF_COUNTS: next_st.stg_counts = 16'(wmerge(32'(st.stg_counts), st.wdata, st.wstrb));
        OFF_STATUS: w1c = st.wstrb[0] ? st.wdata[2:0] : 3'h0;
        OFF_MASK: next_st.mask = st.wstrb[0] ? st.wdata[2:0] : st.mask;
        OFF_MON_LO, OFF_MON_HI, OFF_POS: next_st.bresp = AXI_OKAY;
        default: next_st.bresp = AXI_SLVERR;
      endcase
    end

    // register read
    if (st.rvalid && S_AXI_RREADY) begin
      next_st.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = AXI_OKAY;
      unique case (raddr)
        OFF_CTRL: next_st.rdata = 32'({st.serial, st.cfg_err, 1'b0});
        OFF_RES: next_st.rdata = 32'(st.stg_res);
        OFF_DIR: next_st.rdata = 32'(st.stg_dir);
        OFF_PITCH: next_st.rdata = st.stg_pitch;
        OFF_SPEED: next_st.rdata = 32'(st.stg_speed);
        OFF_COUNTS: next_st.rdata = 32'(st.stg_counts);
        OFF_STATUS: next_st.rdata = 32'(st.status);
        OFF_MASK: next_st.rdata = 32'(st.mask);
        OFF_MON_LO: next_st.rdata = 32'(st.mon_pitch[15:0]);
        OFF_MON_HI: next_st.rdata = 32'(st.mon_pitch[31:16]);
        OFF_POS: next_st.rdata = st.pos;
        default: begin
          next_st.rdata = 32'h0000_0000;
          next_st.rresp = AXI_SLVERR;
        end
      endcase
    end

    // R15 parameters taken only here
    if (restart) begin
      // R10 recognised pitch overrides the setting unless a serial converter is present
      pitch_sel = auto_ok ? PITCH_AUTO : st.stg_pitch;
      next_st.mon_pitch = auto_ok ? PITCH_AUTO : 32'h0000_0000;
      // R7 resolution times 100 times speed within pitch times 72
      lhs = 48'(st.stg_res) * LIMIT_DEN * 48'(st.stg_speed);
      rhs = 48'(pitch_sel) * LIMIT_NUM;
      // R5 R8 range and limit check
      err = (st.stg_res < RES_MIN) | (st.stg_res > RES_MAX) | (st.stg_speed == 16'h0000) |
            (st.stg_counts == 16'h0000) | (16'(st.stg_res) > st.stg_counts) | (lhs > rhs);
      next_st.res = st.stg_res;
      next_st.dir = st.stg_dir;
      next_st.serial = ser_q;
      next_st.counts = st.stg_counts;
      next_st.cfg_err = err;
      next_st.acc = 16'h0000;
      next_st.spc = 3'h0;
      next_st.fill = 3'h0;
      next_st.idx_on = 1'b0;
      slot_clear = 1'b1;
    end

    // sticky status, set wins over clear
    set[ST_SET_ERR] = err;
    set[ST_OVERSPEED] = ovs;
    set[ST_INDEX] = emit;
    next_st.status = (st.status & ~w1c) | set;

    // registered outputs
    next_st.awready = ~next_st.aw_held & ~next_st.bvalid;
    next_st.wready = ~next_st.w_held & ~next_st.bvalid;
    next_st.arready = ~next_st.rvalid;
    next_st.qa = (next_st.q == 2'h1) | (next_st.q == 2'h2);
    next_st.qb = (next_st.q == 2'h2) | (next_st.q == 2'h3);
    next_st.qidx = next_st.idx_on;
    next_st.irq = |(next_st.status & next_st.mask);
    next_st.al_set = next_st.cfg_err;
    next_st.al_ovs = next_st.status[ST_OVERSPEED];
  end

  // state register
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      st <= '0;
      st.boot <= BOOT_CYC;
      st.stg_res <= RES_RST;
      st.stg_dir <= DIR_RST;
      st.stg_pitch <= PITCH_RST;
      st.stg_speed <= SPEED_RST;
      st.stg_counts <= COUNTS_RST;
      st.res <= RES_RST;
      st.dir <= DIR_RST;
      st.counts <= COUNTS_RST;
      st.mask <= MASK_RST;
    end else begin
      st <= next_st;
    end
  end

  assign S_AXI_AWREADY = st.awready;
  assign S_AXI_WREADY = st.wready;
  assign S_AXI_BVALID = st.bvalid;
  assign S_AXI_BRESP = st.bresp;
  assign S_AXI_ARREADY = st.arready;
  assign S_AXI_RVALID = st.rvalid;
  assign S_AXI_RDATA = st.rdata;
  assign S_AXI_RRESP = st.rresp;
  assign QUAD_OUT_A = st.qa;
  assign QUAD_OUT_B = st.qb;
  assign INDEX_OUT = st.qidx;
  assign ALARM_SET_ERR = st.al_set;
  assign ALARM_OVERSPEED = st.al_ovs;
  assign IRQ = st.irq;
endmodule

/* File: sim/epod_assertions.sv */
// concurrent checks on the ports of the pulse divider top
`timescale 1ns/10ps
module epod_assertions (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic QUAD_OUT_A,
  input wire logic QUAD_OUT_B,
  input wire logic INDEX_OUT,
  input wire logic ALARM_SET_ERR,
  input wire logic ALARM_OVERSPEED,
  input wire logic IRQ
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  logic pa, pb, edge_a, edge_b;
  logic [3:0] wr_age;
  logic [2:0] qe_cnt;
  // output edge detect against last cycle
  assign edge_a = pa ^ QUAD_OUT_A;
  assign edge_b = pb ^ QUAD_OUT_B;
  // age of last write address and edges seen while index is high
  always_ff @(posedge CORE_CLK) begin
    pa <= QUAD_OUT_A;
    pb <= QUAD_OUT_B;
    if (SYS_RST || (S_AXI_AWVALID && S_AXI_AWREADY)) begin
      wr_age <= 4'h0;
    end else if (wr_age != 4'hf) begin
      wr_age <= wr_age + 4'h1;
    end
    if (SYS_RST || !INDEX_OUT) begin
      qe_cnt <= 3'h0;
    end else if ((edge_a || edge_b) && qe_cnt != 3'h7) begin
      qe_cnt <= qe_cnt + 3'h1;
    end
  end
  chk_quad_one_step: assert property (!(edge_a && edge_b))
    else $error("both quadrature outputs moved at once");
  chk_err_freezes: assert property (ALARM_SET_ERR && $past(ALARM_SET_ERR) |->
    !edge_a && !edge_b) else $error("output edge during setting error");
  chk_err_at_restart: assert property ($changed(ALARM_SET_ERR) |-> wr_age < 4'h6)
    else $error("setting error changed without restart");
  chk_ovs_sticky: assert property (ALARM_OVERSPEED && wr_age > 4'h2 &&
    !(S_AXI_AWVALID && S_AXI_AWREADY) |=> ALARM_OVERSPEED) else $error("overspeed lost");
  chk_idx_width: assert property ($fell(INDEX_OUT) |->
    (wr_age < 4'h5 || qe_cnt + 3'(edge_a | edge_b) >= 3'h2) or ##1 (edge_a || edge_b))
    else $error("index dropped before two edges");
  chk_quiet_reset: assert property ($fell(SYS_RST) |->
    !QUAD_OUT_A && !QUAD_OUT_B && !INDEX_OUT && !IRQ) else $error("outputs busy after reset");
  chk_aw_refused: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write accepted while response pending");
  chk_b_holds: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write response dropped");
  chk_r_holds: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data dropped");
  chk_rd_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=>
    S_AXI_RVALID && !S_AXI_ARREADY) else $error("read answer late");
  chk_wr_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID &&
    S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID) else $error("write answer late");
  cov_overspeed: cover property ($rose(ALARM_OVERSPEED));
  cov_index: cover property ($rose(INDEX_OUT));
  cov_set_err: cover property ($rose(ALARM_SET_ERR));
endmodule

bind epod_top epod_assertions u_chk (.*);

/* File: sim/epod_host_model.sv */
// host counter that follows the divided quadrature and index outputs
`timescale 1ns/10ps
module epod_host_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic quad_a,
  input wire logic quad_b,
  input wire logic index_in,
  output int pos,
  output int index_cnt,
  output int bad_cnt
);
  logic [1:0] cur, last;
  logic last_idx;
  // phase of the pair: 00 0, 10 1, 11 2, 01 3
  assign cur = {quad_b, quad_a ^ quad_b};
  // count up, down, flag skipped phases, count index rises
  always_ff @(posedge clk) begin
    last <= cur;
    last_idx <= index_in;
    if (rst) begin
      pos <= 0;
      index_cnt <= 0;
      bad_cnt <= 0;
    end else begin
      case (cur - last)
        2'h1: pos <= pos + 1;
        2'h3: pos <= pos - 1;
        2'h2: bad_cnt <= bad_cnt + 1;
        default: ;
      endcase
      if (index_in && !last_idx) begin
        index_cnt <= index_cnt + 1;
      end
    end
  end
endmodule

/* File: sim/encoder_pulse_output_divider_tb.sv */
// self-checking bench for the encoder pulse output divider
`timescale 1ns/10ps
module encoder_pulse_output_divider_tb;
  import epod_pkg::*;
  logic CORE_CLK, SYS_RST, SCALE_A, SCALE_B, SCALE_Z, SERIAL_CONV, PITCH_AUTO_VALID;
  logic [31:0] PITCH_AUTO, S_AXI_WDATA, S_AXI_RDATA;
  logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [3:0] S_AXI_WSTRB;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, code;
  logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID;
  logic S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  logic QUAD_OUT_A, QUAD_OUT_B, INDEX_OUT, ALARM_SET_ERR, ALARM_OVERSPEED, IRQ;
  int num_errors, num_checks, seed, hpos, hidx, hbad, acc, q, res, cnts, base, h;
  logic [7:0] ra[10] = '{OFF_RES, OFF_DIR, OFF_PITCH, OFF_SPEED, OFF_COUNTS, OFF_MASK,
    OFF_MON_LO, OFF_MON_HI, OFF_CTRL, 8'h3c};
  logic [31:0] rv[10] = '{32'(RES_RST), 32'(DIR_RST), PITCH_RST, 32'(SPEED_RST),
    32'(COUNTS_RST), 32'(MASK_RST), 32'h0, 32'h0, 32'h0, 32'h0};
  int er_r[6] = '{28, 29, 0, 4096, 4097, 50};
  int er_p[6] = '{2000, 2000, 2000, 6000, 6000, 2000};
  int er_s[6] = '{50, 50, 50, 1, 1, 50};
  int er_c[6] = '{1024, 1024, 1024, 4096, 4096, 1024};
  epod_top dut (.*);
  epod_host_model host (.clk(CORE_CLK), .rst(SYS_RST), .quad_a(QUAD_OUT_A),
    .quad_b(QUAD_OUT_B), .index_in(INDEX_OUT), .pos(hpos), .index_cnt(hidx), .bad_cnt(hbad));
  // free-running core clock
  initial begin
    CORE_CLK = 1'b0;
    forever #5 CORE_CLK = ~CORE_CLK;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // setting error expected from resolution, pitch, speed and counts
  function automatic logic err_of(input longint r, input longint p, input longint s,
                                  input longint c);
    err_of = r < 1 || r > 4096 || s == 0 || c == 0 || r > c || r * 100 * s > p * 72;
  endfunction
  // divider model: one feedback count forward or back
  function automatic void div_step(input bit fwd);
    if (fwd) begin
      acc += res;
      if (acc >= cnts) begin
        acc -= cnts;
        q++;
      end
    end else if (acc >= res) begin
      acc -= res;
    end else begin
      acc += cnts - res;
      q--;
    end
  endfunction
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit b;
    int n;
    int dly;
    b = 0;
    n = 0;
    dly = $unsigned($random(seed)) % 3;
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    while (!b && n < 40) begin
      @(posedge CORE_CLK);
      n++;
      if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        b = 1;
        check(S_AXI_BRESP, er, "bresp");
        S_AXI_BREADY <= 1'b0;
      end else if (n > dly) begin
        S_AXI_BREADY <= 1'b1;
      end
    end
    check(32'(b), 1, "write hang");
    @(posedge CORE_CLK);
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    bit b;
    int n;
    int dly;
    b = 0;
    n = 0;
    dly = $unsigned($random(seed)) % 3;
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    while (!b && n < 40) begin
      @(posedge CORE_CLK);
      n++;
      if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      if (S_AXI_RVALID && S_AXI_RREADY) begin
        b = 1;
        check(S_AXI_RDATA, e, "rdata");
        check(S_AXI_RRESP, er, "rresp");
        S_AXI_RREADY <= 1'b0;
      end else if (n > dly) begin
        S_AXI_RREADY <= 1'b1;
      end
    end
    check(32'(b), 1, "read hang");
    @(posedge CORE_CLK);
  endtask
  task automatic cfg(input int r, input int p, input int s, input int c, input int d);
    axi_wr(OFF_RES, 32'(r), AXI_OKAY);
    axi_wr(OFF_PITCH, 32'(p), AXI_OKAY);
    axi_wr(OFF_SPEED, 32'(s), AXI_OKAY);
    axi_wr(OFF_COUNTS, 32'(c), AXI_OKAY);
    axi_wr(OFF_DIR, 32'(d), AXI_OKAY);
    axi_wr(OFF_CTRL, 32'h1, AXI_OKAY);
    repeat (4) @(posedge CORE_CLK);
    res = r;
    cnts = c;
    acc = 0;
    q = 0;
    base = hpos;
  endtask
  // scale steps at the pins, gap cycles apart
  task automatic mv(input bit fwd, input int n, input int gap);
    repeat (n) begin
      code = fwd ? code + 2'h1 : code - 2'h1;
      SCALE_A <= code[1] ^ code[0];
      SCALE_B <= code[1];
      div_step(fwd);
      repeat (gap) @(posedge CORE_CLK);
    end
  endtask
  task automatic zp(input int e);
    h = hidx;
    SCALE_Z <= 1'b1;
    repeat (4) @(posedge CORE_CLK);
    SCALE_Z <= 1'b0;
    repeat (8) @(posedge CORE_CLK);
    check(hidx - h, e, "index count");
  endtask
  initial begin
    #200_000;
    num_errors++;
    tally_and_finish;
  end
  // main sequence
  initial begin
    seed = 4;
    {SYS_RST, SCALE_A, SCALE_B, SCALE_Z, SERIAL_CONV, PITCH_AUTO_VALID} = 6'h20;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h0;
    {PITCH_AUTO, S_AXI_WDATA, S_AXI_AWADDR, S_AXI_ARADDR} = '0;
    S_AXI_WSTRB = 4'hf;
    code = 2'h0;
    repeat (4) @(posedge CORE_CLK);
    SYS_RST <= 1'b0;
    repeat (8) @(posedge CORE_CLK);
    for (int i = 0; i < 10; i++) axi_rd(ra[i], rv[i], i == 9 ? AXI_SLVERR : AXI_OKAY);
    axi_wr(8'h3c, 32'h5, AXI_SLVERR);
    axi_wr(OFF_RES, 32'd29, AXI_OKAY);
    repeat (4) @(posedge CORE_CLK);
    check(ALARM_SET_ERR, 1'b0, "staged only");
    PITCH_AUTO <= 32'h0001_1170;
    for (int i = 0; i < 6; i++) begin
      PITCH_AUTO_VALID <= i == 5;
      cfg(er_r[i], er_p[i], er_s[i], er_c[i], 0);
      h = err_of(er_r[i], i == 5 ? 70000 : er_p[i], er_s[i], er_c[i]);
      check(ALARM_SET_ERR, h[0], "setting error");
      axi_rd(OFF_CTRL, {29'h0, 1'b0, h[0], 1'b0}, AXI_OKAY);
      mv(1, 2, 6);
      check(hpos - base, h[0] ? 0 : q, "frozen");
    end
    axi_rd(OFF_MON_LO, 32'h1170, AXI_OKAY);
    axi_rd(OFF_MON_HI, 32'h1, AXI_OKAY);
    PITCH_AUTO_VALID <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      cfg(k == 0 ? 1 : k == 1 ? 16 : 1 + $unsigned($random(seed)) % 16, 2000, 50, 16, 0);
      repeat (300) mv($random(seed) & 1, 1, 6);
      check(hpos - base, q, "quad count");
    end
    check(hbad, 0, "skipped phase");
    check(ALARM_OVERSPEED, 1'b0, "no overspeed");
    cfg(8, 2000, 50, 8, 0);
    for (int k = 0; k < 2; k++) begin
      mv(0, 1, 6);
      zp(0);
      mv(1, 1, 6);
      zp(1);
      mv(1, 3, 6);
      h = hidx;
      mv(0, 3, 6);
      check(hidx - h, 1, "stored point");
      mv(1, 6, 6);
    end
    check(hpos - base, q, "quad count");
    cfg(8, 2000, 50, 8, 1);
    mv(0, 1, 6);
    zp(1);
    mv(1, 3, 6);
    SERIAL_CONV <= 1'b1;
    cfg(8, 2000, 50, 8, 0);
    mv(0, 1, 6);
    zp(1);
    SERIAL_CONV <= 1'b0;
    cfg(16, 2000, 50, 16, 0);
    axi_wr(OFF_STATUS, 32'h7, AXI_OKAY);
    axi_wr(OFF_MASK, 32'h2, AXI_OKAY);
    mv(1, 20, 2);
    repeat (6) @(posedge CORE_CLK);
    check(ALARM_OVERSPEED, 1'b1, "overspeed");
    check(IRQ, 1'b1, "irq raised");
    axi_wr(OFF_MASK, 32'h0, AXI_OKAY);
    repeat (2) @(posedge CORE_CLK);
    check(IRQ, 1'b0, "irq masked");
    axi_wr(OFF_STATUS, 32'h2, AXI_OKAY);
    repeat (2) @(posedge CORE_CLK);
    check(ALARM_OVERSPEED, 1'b0, "overspeed cleared");
    tally_and_finish;
  end
endmodule
